// ==== rtl/mfpm_params.svh ====
// Constants for the multifunction pad mux: pad numbers, function codes, pull defaults.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MFPM_PARAMS_SVH
`define MFPM_PARAMS_SVH

`define MFPM_NUM_PADS        32
`define MFPM_SEL_W           3
// Pad numbers handled by this block
`define MFPM_PAD_EXT_RADIO_ACTIVITY_IND   13
`define MFPM_PAD_EXT_RADIO_BAND_IND    14
`define MFPM_PAD_EXT_GRANT   15
`define MFPM_PAD_BT_WAKE     16
`define MFPM_PAD_TSF_OUT     17
`define MFPM_PAD_HS_CTS      18
`define MFPM_PAD_HS_RTS      19
`define MFPM_PAD_HS_RX       20
`define MFPM_PAD_HS_TX       21
`define MFPM_PAD_TRIG0       22
`define MFPM_PAD_TRIG1       23
`define MFPM_PAD_MICRO_SYNC  24
`define MFPM_PAD_COEX_B      25
`define MFPM_PAD_COEX_A      26
`define MFPM_PAD_TCK         27
`define MFPM_PAD_TMS         28
`define MFPM_PAD_TDI         29
`define MFPM_PAD_TDO         30
`define MFPM_PAD_PERST       31
// Function select codes, per pad
`define MFPM_FN_GPIO         3'h0
`define MFPM_FN_ALT1         3'h1
`define MFPM_FN_ALT2         3'h2
`define MFPM_FN_ALT3         3'h3
// Select word before firmware writes it; JTAG defaults come from the phase, not this word
`define MFPM_FN_RESET        96'h0
`define MFPM_PULL_UP_RESET   32'hFFFFFFFF
`define MFPM_PULL_DN_RESET   32'h00000000
`define MFPM_SLEEP_OE_RESET  32'h00000000
`define MFPM_SLEEP_VAL_RESET 32'h00000000

`endif

// ==== rtl/mfpm_pkg.sv ====
// Types for the multifunction pad mux.
// Assumes mfpm_params.svh is on the include path.
`include "mfpm_params.svh"
package mfpm_pkg;
  // Pad phase sequence after power-on reset
  typedef enum logic [4:0] {
    MFPM_ST_RESET    = 5'h01,
    MFPM_ST_POSTBOOT = 5'h02,
    MFPM_ST_DOWNLOAD = 5'h04,
    MFPM_ST_FUNC     = 5'h08,
    MFPM_ST_SLEEP    = 5'h10
  } mfpm_phase_t;

  typedef logic [`MFPM_SEL_W-1:0] mfpm_sel_t;
endpackage : mfpm_pkg

// ==== rtl/mfpm_sync_if.sv ====
// Interface carrying raw and synchronised pad inputs between the top and the synchroniser.
// Assumes one clock domain on the receiving side.
`timescale 1ns/10ps
`include "mfpm_params.svh"
interface mfpm_sync_if;
  logic [`MFPM_NUM_PADS-1:0] raw;
  logic [`MFPM_NUM_PADS-1:0] sync;
  modport top  (output raw, input sync);
  modport sync_side (input raw, output sync);
endinterface : mfpm_sync_if

// ==== rtl/mfpm_sync.sv ====
// Two-flop synchroniser for every pad input.
// Assumes pad inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`include "mfpm_params.svh"
module mfpm_sync (
  input wire logic    clk_sys,
  input wire logic    rst,
  mfpm_sync_if.sync_side sif
);
  logic [`MFPM_NUM_PADS-1:0] meta_ff;
  logic [`MFPM_NUM_PADS-1:0] sync_ff;
  logic [`MFPM_NUM_PADS-1:0] nxt_meta;
  logic [`MFPM_NUM_PADS-1:0] nxt_sync;

  always_comb begin
    nxt_meta = sif.raw;
    nxt_sync = meta_ff;
  end

  // Idle pads float high through the weak pull-up, so synchronisers reset high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_ff <= `MFPM_PULL_UP_RESET;
      sync_ff <= `MFPM_PULL_UP_RESET;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sif.sync = sync_ff;
endmodule : mfpm_sync

// ==== rtl/mfpm_pad_mux.sv ====
// Multifunction pad mux: pad phase sequencing, per-pad function select, pulls, sleep values.
// Assumes boot/download/sleep status from the system controller on clk_sys.
`timescale 1ns/10ps
`include "mfpm_params.svh"
module mfpm_pad_mux (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Phase status from the system controller
  input  wire logic                          boot_done,
  input  wire logic                          download_start,
  input  wire logic                          download_done,
  input  wire logic                          sleep_req,
  input  wire logic                          strap_pcie_serial,
  // Firmware configuration
  input  wire logic [3*`MFPM_NUM_PADS-1:0]   fn_sel,
  input  wire logic [`MFPM_NUM_PADS-1:0]     pull_up_en,
  input  wire logic [`MFPM_NUM_PADS-1:0]     pull_dn_en,
  input  wire logic [`MFPM_NUM_PADS-1:0]     sleep_oe,
  input  wire logic [`MFPM_NUM_PADS-1:0]     sleep_val,
  input  wire logic                          tsf_src_mac2,
  // Plain GPIO
  input  wire logic [`MFPM_NUM_PADS-1:0]     gpio_out,
  input  wire logic [`MFPM_NUM_PADS-1:0]     gpio_oe,
  output logic      [`MFPM_NUM_PADS-1:0]     gpio_in,
  // Function-side signals
  input  wire logic                          jtag_tdo,
  output logic                               jtag_tck,
  output logic                               jtag_tms,
  output logic                               jtag_tdi,
  output logic                               pcie_reset_n,
  input  wire logic                          coex_serial_tx,
  output logic                               coex_serial_rx,
  input  wire logic                          wci2_tx,
  output logic                               wci2_rx,
  input  wire logic                          host_serial_tx,
  output logic                               host_serial_rx,
  input  wire logic                          host_serial_request_to_send_n,
  output logic                               host_serial_clear_to_send_n,
  input  wire logic                          ext_radio_grant,
  output logic                               ext_radio_band_ind,
  output logic                               ext_radio_activity_ind,
  output logic                               debug_serial_rx,
  input  wire logic                          debug_serial_tx,
  input  wire logic [1:0]                    narrowband_trigger_out,
  input  wire logic [1:0]                    narrowband_trigger_oe,
  output logic      [1:0]                    narrowband_trigger_in,
  input  wire logic                          tsf_sync_mac1,
  input  wire logic                          tsf_sync_mac2,
  output logic                               micro_timer_sync_in,
  output logic                               le_audio_sync_alt,
  output logic                               bt_wake_input,
  output mfpm_pkg::mfpm_phase_t              pad_phase,
  // Pads
  input  wire logic [`MFPM_NUM_PADS-1:0]     pad_in,
  output logic      [`MFPM_NUM_PADS-1:0]     pad_out,
  output logic      [`MFPM_NUM_PADS-1:0]     pad_oe,
  output logic      [`MFPM_NUM_PADS-1:0]     pad_pull_up,
  output logic      [`MFPM_NUM_PADS-1:0]     pad_pull_dn
);
  mfpm_pkg::mfpm_phase_t       phase_ff;
  mfpm_pkg::mfpm_phase_t       nxt_phase;
  logic                        strap_ff;
  logic                        nxt_strap;
  logic [`MFPM_NUM_PADS-1:0]   out_ff;
  logic [`MFPM_NUM_PADS-1:0]   oe_ff;
  logic [`MFPM_NUM_PADS-1:0]   nxt_out;
  logic [`MFPM_NUM_PADS-1:0]   nxt_oe;
  logic [`MFPM_NUM_PADS-1:0]   pin;
  mfpm_pkg::mfpm_sel_t         sel [`MFPM_NUM_PADS];

  mfpm_sync_if sif ();
  assign sif.raw = pad_in;
  assign pin     = sif.sync;

  mfpm_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sif     (sif)
  );

  // Effective selection: firmware select in the functional phase only; JTAG defaults on TDO and TMS in every other phase
  always_comb begin
    for (int i = 0; i < `MFPM_NUM_PADS; i++) begin
      if (phase_ff == mfpm_pkg::MFPM_ST_FUNC) begin
        sel[i] = fn_sel[3*i +: 3];
      end else if (i == `MFPM_PAD_TDO || i == `MFPM_PAD_TMS) begin
        sel[i] = `MFPM_FN_ALT1;
      end else begin
        sel[i] = `MFPM_FN_GPIO;
      end
    end
  end

  // Phase sequencing
  always_comb begin
    nxt_phase = phase_ff;
    nxt_strap = strap_ff;
    unique case (phase_ff)
      mfpm_pkg::MFPM_ST_RESET: begin
        nxt_strap = strap_pcie_serial;
        if (boot_done) begin
          nxt_phase = mfpm_pkg::MFPM_ST_POSTBOOT;
        end
      end
      mfpm_pkg::MFPM_ST_POSTBOOT: begin
        if (download_start) begin
          nxt_phase = mfpm_pkg::MFPM_ST_DOWNLOAD;
        end
      end
      mfpm_pkg::MFPM_ST_DOWNLOAD: begin
        if (download_done) begin
          nxt_phase = mfpm_pkg::MFPM_ST_FUNC;
        end
      end
      mfpm_pkg::MFPM_ST_FUNC: begin
        if (sleep_req) begin
          nxt_phase = mfpm_pkg::MFPM_ST_SLEEP;
        end
      end
      mfpm_pkg::MFPM_ST_SLEEP: begin
        if (!sleep_req) begin
          nxt_phase = mfpm_pkg::MFPM_ST_FUNC;
        end
      end
      default: nxt_phase = mfpm_pkg::MFPM_ST_RESET;
    endcase
  end

  // Pad drive per phase and function
  always_comb begin
    nxt_out = '0;
    nxt_oe  = '0;
    for (int i = 0; i < `MFPM_NUM_PADS; i++) begin
      if (sel[i] == `MFPM_FN_GPIO) begin
        nxt_out[i] = gpio_out[i];
        nxt_oe[i]  = gpio_oe[i] && (phase_ff == mfpm_pkg::MFPM_ST_FUNC);
      end
    end
    unique case (phase_ff)
      mfpm_pkg::MFPM_ST_RESET, mfpm_pkg::MFPM_ST_DOWNLOAD: begin
        nxt_out[`MFPM_PAD_TDO] = 1'b1;
        nxt_oe[`MFPM_PAD_TDO]  = 1'b1;
      end
      mfpm_pkg::MFPM_ST_POSTBOOT: begin
        nxt_out[`MFPM_PAD_TDO] = 1'b1;
        nxt_oe[`MFPM_PAD_TDO]  = 1'b1;
        if (strap_ff) begin
          nxt_out[`MFPM_PAD_HS_RTS] = 1'b1;
          nxt_oe[`MFPM_PAD_HS_RTS]  = 1'b1;
          nxt_out[`MFPM_PAD_HS_TX]  = 1'b0;
          nxt_oe[`MFPM_PAD_HS_TX]   = 1'b1;
        end
      end
      mfpm_pkg::MFPM_ST_FUNC: begin
        if (sel[`MFPM_PAD_TDO] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_TDO] = jtag_tdo;
          nxt_oe[`MFPM_PAD_TDO]  = 1'b1;
        end
        if (sel[`MFPM_PAD_COEX_A] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_COEX_A] = coex_serial_tx;
          nxt_oe[`MFPM_PAD_COEX_A]  = 1'b1;
        end
        if (sel[`MFPM_PAD_COEX_B] == `MFPM_FN_ALT2) begin
          nxt_out[`MFPM_PAD_COEX_B] = wci2_tx;
          nxt_oe[`MFPM_PAD_COEX_B]  = 1'b1;
        end
        if (sel[`MFPM_PAD_HS_TX] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_HS_TX] = host_serial_tx;
          nxt_oe[`MFPM_PAD_HS_TX]  = 1'b1;
        end
        if (sel[`MFPM_PAD_HS_RTS] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_HS_RTS] = host_serial_request_to_send_n;
          nxt_oe[`MFPM_PAD_HS_RTS]  = 1'b1;
        end
        if (sel[`MFPM_PAD_EXT_GRANT] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_EXT_GRANT] = ext_radio_grant;
          nxt_oe[`MFPM_PAD_EXT_GRANT]  = 1'b1;
        end
        if (sel[`MFPM_PAD_EXT_RADIO_ACTIVITY_IND] == `MFPM_FN_ALT2) begin
          nxt_out[`MFPM_PAD_EXT_RADIO_ACTIVITY_IND] = debug_serial_tx;
          nxt_oe[`MFPM_PAD_EXT_RADIO_ACTIVITY_IND]  = 1'b1;
        end
        if (sel[`MFPM_PAD_TRIG0] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_TRIG0] = narrowband_trigger_out[0];
          nxt_oe[`MFPM_PAD_TRIG0]  = narrowband_trigger_oe[0];
        end
        if (sel[`MFPM_PAD_TRIG1] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_TRIG1] = narrowband_trigger_out[1];
          nxt_oe[`MFPM_PAD_TRIG1]  = narrowband_trigger_oe[1];
        end
        if (sel[`MFPM_PAD_TSF_OUT] == `MFPM_FN_ALT1) begin
          nxt_out[`MFPM_PAD_TSF_OUT] = tsf_src_mac2 ? tsf_sync_mac2 : tsf_sync_mac1;
          nxt_oe[`MFPM_PAD_TSF_OUT]  = 1'b1;
        end
      end
      mfpm_pkg::MFPM_ST_SLEEP: begin
        nxt_out = sleep_val;
        nxt_oe  = sleep_oe;
      end
      default: begin
        nxt_out = '0;
        nxt_oe  = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_ff <= mfpm_pkg::MFPM_ST_RESET;
      strap_ff <= 1'b0;
      out_ff   <= '0;
      oe_ff    <= '0;
    end else begin
      phase_ff <= nxt_phase;
      strap_ff <= nxt_strap;
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
    end
  end

  // Reset state already shows TDO high from the first cycle of reset
  always_comb begin
    pad_out = out_ff;
    pad_oe  = oe_ff;
    if (phase_ff == mfpm_pkg::MFPM_ST_RESET) begin
      pad_out[`MFPM_PAD_TDO] = 1'b1;
      pad_oe[`MFPM_PAD_TDO]  = 1'b1;
    end
  end

  // Pulls act on input pads only; defaults before firmware takes over
  always_comb begin
    for (int i = 0; i < `MFPM_NUM_PADS; i++) begin
      if (phase_ff == mfpm_pkg::MFPM_ST_FUNC || phase_ff == mfpm_pkg::MFPM_ST_SLEEP) begin
        pad_pull_up[i] = pull_up_en[i] && !pad_oe[i];
        pad_pull_dn[i] = pull_dn_en[i] && !pad_oe[i];
      end else begin
        pad_pull_up[i] = 1'(`MFPM_PULL_UP_RESET >> i) && !pad_oe[i];
        pad_pull_dn[i] = 1'b0;
      end
    end
  end

  // Input routing; unselected functions see their idle level
  always_comb begin
    gpio_in = '1;
    for (int i = 0; i < `MFPM_NUM_PADS; i++) begin
      if (sel[i] == `MFPM_FN_GPIO) begin
        gpio_in[i] = pin[i];
      end
    end
    jtag_tck    = (sel[`MFPM_PAD_TCK] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_TCK] : 1'b0;
    jtag_tms    = (sel[`MFPM_PAD_TMS] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_TMS] : 1'b1;
    jtag_tdi    = (sel[`MFPM_PAD_TDI] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_TDI] : 1'b1;
    le_audio_sync_alt = (sel[`MFPM_PAD_TDI] == `MFPM_FN_ALT2) ? pin[`MFPM_PAD_TDI] : 1'b0;
    pcie_reset_n = (sel[`MFPM_PAD_PERST] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_PERST] : 1'b1;
    coex_serial_rx = (sel[`MFPM_PAD_COEX_B] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_COEX_B] : 1'b1;
    wci2_rx = (sel[`MFPM_PAD_COEX_A] == `MFPM_FN_ALT2) ? pin[`MFPM_PAD_COEX_A] : 1'b1;
    host_serial_rx = (sel[`MFPM_PAD_HS_RX] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_HS_RX] : 1'b1;
    host_serial_clear_to_send_n =
      (sel[`MFPM_PAD_HS_CTS] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_HS_CTS] : 1'b1;
    ext_radio_band_ind =
      (sel[`MFPM_PAD_EXT_RADIO_BAND_IND] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_EXT_RADIO_BAND_IND] : 1'b0;
    ext_radio_activity_ind =
      (sel[`MFPM_PAD_EXT_RADIO_ACTIVITY_IND] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_EXT_RADIO_ACTIVITY_IND] : 1'b0;
    debug_serial_rx =
      (sel[`MFPM_PAD_EXT_RADIO_BAND_IND] == `MFPM_FN_ALT2) ? pin[`MFPM_PAD_EXT_RADIO_BAND_IND] : 1'b1;
    narrowband_trigger_in[0] =
      (sel[`MFPM_PAD_TRIG0] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_TRIG0] : 1'b0;
    narrowband_trigger_in[1] =
      (sel[`MFPM_PAD_TRIG1] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_TRIG1] : 1'b0;
    micro_timer_sync_in =
      (sel[`MFPM_PAD_MICRO_SYNC] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_MICRO_SYNC] : 1'b0;
    bt_wake_input =
      (sel[`MFPM_PAD_BT_WAKE] == `MFPM_FN_ALT1) ? pin[`MFPM_PAD_BT_WAKE] : 1'b0;
  end

  assign pad_phase = phase_ff;
endmodule : mfpm_pad_mux

// ==== verification/mfpm_pad_mux_monitor.sv ====
// Checker for the pad mux: phase order, pad drive, pulls, pad-to-function paths.
// Assumes it is bound to mfpm_pad_mux and sees only its ports.
`timescale 1ns/10ps
module mfpm_pad_mux_monitor (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  boot_done,
  input wire logic                  download_done,
  input wire logic                  strap_pcie_serial,
  input wire logic [95:0]           fn_sel,
  input wire logic [31:0]           pull_up_en,
  input wire logic [31:0]           pull_dn_en,
  input wire logic [31:0]           sleep_oe,
  input wire logic [31:0]           sleep_val,
  input wire logic                  ext_radio_grant,
  input wire logic                  pcie_reset_n,
  input wire mfpm_pkg::mfpm_phase_t pad_phase,
  input wire logic [31:0]           pad_in,
  input wire logic [31:0]           pad_out,
  input wire logic [31:0]           pad_oe,
  input wire logic [31:0]           pad_pull_up,
  input wire logic [31:0]           pad_pull_dn
);
  wire logic is_rs = pad_phase == mfpm_pkg::MFPM_ST_RESET;
  wire logic is_pb = pad_phase == mfpm_pkg::MFPM_ST_POSTBOOT;
  wire logic is_dl = pad_phase == mfpm_pkg::MFPM_ST_DOWNLOAD;
  wire logic is_fn = pad_phase == mfpm_pkg::MFPM_ST_FUNC;
  wire logic is_sl = pad_phase == mfpm_pkg::MFPM_ST_SLEEP;
  default clocking mon_cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_reset_entry: assert property ($fell(rst) |-> is_rs)
    else $error("phase not reset after release");
  a_tdo_reset: assert property (is_rs |-> pad_oe[30] && pad_out[30])
    else $error("pad 30 not high in reset");
  a_boot_step: assert property (is_rs && boot_done |=> is_pb)
    else $error("boot did not reach post-boot");
  a_strap_drive: assert property (
    is_pb && $past(is_rs) && $past(strap_pcie_serial)
    |=> !is_pb || (pad_oe[19] && pad_out[19] && pad_oe[21] && !pad_out[21]))
    else $error("serial pads wrong after strap boot");
  a_func_entry: assert property (is_dl && download_done |=> is_fn)
    else $error("download end did not reach functional");
  a_grant_out: assert property (
    (is_fn && fn_sel[47:45] == 3'h1) [*2] |-> pad_oe[15] && pad_out[15] == $past(ext_radio_grant))
    else $error("grant pad wrong");
  a_sleep_drive: assert property (is_sl && $past(is_sl) |-> pad_oe == $past(sleep_oe) &&
    (pad_out & pad_oe) == ($past(sleep_val) & $past(sleep_oe)))
    else $error("sleep drive wrong");
  a_pull_default: assert property (
    is_rs || is_pb || is_dl |-> pad_pull_up == ~pad_oe && pad_pull_dn == 32'h0)
    else $error("default pulls wrong");
  a_pull_prog: assert property (is_fn || is_sl |->
    pad_pull_up == (pull_up_en & ~pad_oe) && pad_pull_dn == (pull_dn_en & ~pad_oe))
    else $error("programmed pulls wrong");
  a_pcie_reset_path: assert property (
    is_fn && fn_sel[95:93] == 3'h1 |-> pcie_reset_n == $past(pad_in[31], 2))
    else $error("pcie reset does not follow pad 31");
  a_pcie_reset_idle: assert property (fn_sel[95:93] != 3'h1 |-> pcie_reset_n)
    else $error("pcie reset active while unselected");
  c_strap_boot: cover property (is_pb && pad_oe[19]);
  c_sleep_drive: cover property (is_sl && pad_oe != 32'h0);
  c_host_reset: cover property (is_fn && fn_sel[95:93] == 3'h1 && !pcie_reset_n);
endmodule : mfpm_pad_mux_monitor

// ==== verification/mfpm_far_side.sv ====
// Far side of the pads: host, external radios and probe, with pull and float resolution.
// Assumes the bench says which pads it drives; a bare pad with no pull flips every cycle.
`timescale 1ns/10ps
module mfpm_far_side (
  input  wire logic        clk_sys,
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] pad_pull_up,
  input  wire logic [31:0] pad_pull_dn,
  input  wire logic [31:0] ext_drv,
  input  wire logic [31:0] ext_en,
  output logic      [31:0] pad_in
);
  logic [31:0] float_ff = 32'h0;
  always @(posedge clk_sys)
    float_ff <= ~float_ff;
  // Outside parties drive only pads the device leaves as input
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drv)
                | (~pad_oe & ~ext_en & ~pad_pull_dn & (pad_pull_up | float_ff));
endmodule : mfpm_far_side

// ==== verification/test_multifunction_pad_mux.sv ====
// Self-checking bench for the pad mux with a far-side pad model.
// Assumes the design, package, interface, checker and far-side model are compiled first.
`timescale 1ns/10ps
module test_multifunction_pad_mux;
  logic        clk_sys = 1'b0, rst = 1'b1, boot_done = 1'b0, download_start = 1'b0;
  logic        download_done = 1'b0, sleep_req = 1'b0, strap_pcie_serial = 1'b0;
  logic        tsf_src_mac2 = 1'b0;
  logic [95:0] fn_sel = 96'h0;
  logic [31:0] pull_up_en = 32'hFFFFFFFF, pull_dn_en = 32'h0, sleep_oe = 32'h0;
  logic [31:0] sleep_val = 32'h0, gpio_out = 32'h0, gpio_oe = 32'h0, ext_drv = 32'h0;
  logic [31:0] ext_en = 32'h0, eoe, eout, lvl, egp;
  logic [31:0] gpio_in, pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_dn;
  logic [8:0]  fin = 9'h0;
  logic [1:0]  trig_out = 2'h0, trig_oe = 2'h0;
  logic [15:0] fo;
  mfpm_pkg::mfpm_phase_t pad_phase;
  int          fails = 0, compares = 0;
  mfpm_pad_mux u_mfpm_pad_mux (
    .clk_sys, .rst, .boot_done, .download_start, .download_done, .sleep_req, .strap_pcie_serial,
    .fn_sel, .pull_up_en, .pull_dn_en, .sleep_oe, .sleep_val, .tsf_src_mac2, .gpio_out, .gpio_oe,
    .gpio_in, .jtag_tdo(fin[0]), .jtag_tck(fo[0]), .jtag_tms(fo[1]), .jtag_tdi(fo[2]),
    .pcie_reset_n(fo[4]), .coex_serial_tx(fin[1]), .coex_serial_rx(fo[5]), .wci2_tx(fin[2]),
    .wci2_rx(fo[6]), .host_serial_tx(fin[3]), .host_serial_rx(fo[7]),
    .host_serial_request_to_send_n(fin[4]), .host_serial_clear_to_send_n(fo[8]),
    .ext_radio_grant(fin[5]), .ext_radio_band_ind(fo[9]), .ext_radio_activity_ind(fo[10]),
    .debug_serial_rx(fo[11]), .debug_serial_tx(fin[6]), .narrowband_trigger_out(trig_out),
    .narrowband_trigger_oe(trig_oe), .narrowband_trigger_in(fo[15:14]), .tsf_sync_mac1(fin[7]),
    .tsf_sync_mac2(fin[8]), .micro_timer_sync_in(fo[12]), .le_audio_sync_alt(fo[3]),
    .bt_wake_input(fo[13]), .pad_phase, .pad_in, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_dn);
  mfpm_far_side u_mfpm_far_side (.clk_sys, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_dn,
    .ext_drv, .ext_en, .pad_in);
  always #12.5 clk_sys = ~clk_sys;
  function automatic logic [2:0] sl(input int i);
    return fn_sel[3*i +: 3];
  endfunction : sl
  function automatic logic f(input int i, input logic [2:0] c, input logic idle);
    return (sl(i) == c) ? lvl[i] : idle;
  endfunction : f
  function automatic void drv(input int i, input logic [2:0] c, input logic v, input logic e);
    if (sl(i) == c) begin
      eoe[i] = e;
      eout[i] = v;
    end
  endfunction : drv
  function automatic void exp_pads();
    eoe = gpio_oe;
    eout = gpio_out;
    for (int i = 13; i < 32; i++) begin
      if (sl(i) != 3'h0) eoe[i] = 1'b0;
    end
    drv(15, 3'h1, fin[5], 1'b1);
    drv(17, 3'h1, tsf_src_mac2 ? fin[8] : fin[7], 1'b1);
    drv(19, 3'h1, fin[4], 1'b1);
    drv(21, 3'h1, fin[3], 1'b1);
    drv(26, 3'h1, fin[1], 1'b1);
    drv(25, 3'h2, fin[2], 1'b1);
    drv(30, 3'h1, fin[0], 1'b1);
    drv(13, 3'h2, fin[6], 1'b1);
    drv(22, 3'h1, trig_out[0], trig_oe[0]);
    drv(23, 3'h1, trig_out[1], trig_oe[1]);
    lvl = (eoe & eout) | (~eoe & ext_drv);
    egp = lvl;
    for (int i = 13; i < 32; i++) begin
      if (sl(i) != 3'h0) egp[i] = 1'b1;
    end
  endfunction : exp_pads
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check("reset_phase", pad_phase, mfpm_pkg::MFPM_ST_RESET);
    check("reset_pads", {pad_oe, pad_out[30]}, {32'h40000000, 1'b1});
    check("reset_pull", {pad_pull_up, pad_pull_dn}, {32'hBFFFFFFF, 32'h0});
  endtask : do_reset
  task automatic boot_seq(input logic strap);
    logic [31:0] e;
    e = strap ? 32'h40280000 : 32'h40000000;
    strap_pcie_serial = strap;
    {ext_en, ext_drv} = {32'h10000000, 32'h0};
    download_done = 1'b1;
    @(negedge clk_sys);
    check("early_event", pad_phase, mfpm_pkg::MFPM_ST_RESET);
    download_done = 1'b0;
    boot_done = 1'b1;
    @(negedge clk_sys);
    boot_done = 1'b0;
    check("boot_phase", pad_phase, mfpm_pkg::MFPM_ST_POSTBOOT);
    @(negedge clk_sys);
    check("boot_oe", pad_oe, e);
    check("boot_out", pad_out & pad_oe, e & 32'h40080000);
    check("boot_pull", {pad_pull_up, pad_pull_dn}, {~e, 32'h0});
    download_start = 1'b1;
    @(negedge clk_sys);
    download_start = 1'b0;
    check("dl_phase", pad_phase, mfpm_pkg::MFPM_ST_DOWNLOAD);
    @(negedge clk_sys);
    check("dl_oe", pad_oe, 32'h40000000);
    check("dl_jtag_in", {fo[1], gpio_in[28]}, 2'b01);
    download_done = 1'b1;
    @(negedge clk_sys);
    download_done = 1'b0;
    check("func_phase", pad_phase, mfpm_pkg::MFPM_ST_FUNC);
  endtask : boot_seq
  task automatic func_round(input int n);
    logic [2:0] s;
    for (int it = 0; it < n; it++) begin
      for (int i = 13; i < 32; i++) begin
        s = (it == 0) ? 3'h1 : (it == 1) ? 3'h2 : 3'($urandom_range(2));
        if (s == 3'h2 && !(i inside {13, 14, 25, 26, 29})) s = 3'h1;
        fn_sel[3*i +: 3] = s;
      end
      {gpio_out, gpio_oe, ext_drv} = {$urandom, $urandom, $urandom};
      {pull_up_en, pull_dn_en} = {$urandom, $urandom};
      {fin, trig_out, trig_oe, tsf_src_mac2} = 14'($urandom);
      exp_pads();
      ext_en = ~eoe;
      repeat (4) @(negedge clk_sys);
      check("pad_oe", pad_oe, eoe);
      check("pad_out", pad_out & pad_oe, eout & eoe);
      check("func_in", fo, {f(23, 3'h1, 1'b0), f(22, 3'h1, 1'b0), f(16, 3'h1, 1'b0),
        f(24, 3'h1, 1'b0), f(14, 3'h2, 1'b1), f(13, 3'h1, 1'b0), f(14, 3'h1, 1'b0),
        f(18, 3'h1, 1'b1), f(20, 3'h1, 1'b1), f(26, 3'h2, 1'b1), f(25, 3'h1, 1'b1),
        f(31, 3'h1, 1'b1), f(29, 3'h2, 1'b0), f(29, 3'h1, 1'b1), f(28, 3'h1, 1'b1),
        f(27, 3'h1, 1'b0)});
      check("gpio_in", gpio_in, egp);
    end
  endtask : func_round
  initial begin
    void'($urandom(32));
    do_reset();
    boot_seq(1'b1);
    func_round(30);
    for (int k = 0; k < 3; k++) begin
      sleep_req = 1'b1;
      ext_en = 32'h0;
      {sleep_oe, sleep_val} = (k == 0) ? 64'h0 : {$urandom, $urandom};
      repeat (3) @(negedge clk_sys);
      check("sleep_phase", pad_phase, mfpm_pkg::MFPM_ST_SLEEP);
      check("sleep_pads", {pad_oe, pad_out & pad_oe}, {sleep_oe, sleep_val & sleep_oe});
    end
    sleep_req = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("wake_phase", pad_phase, mfpm_pkg::MFPM_ST_FUNC);
    do_reset();
    boot_seq(1'b0);
    func_round(5);
    tally_and_finish();
  end
  // About 24 times the expected run of about 170 cycles
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule : test_multifunction_pad_mux
bind mfpm_pad_mux mfpm_pad_mux_monitor u_mfpm_pad_mux_monitor (.clk_sys, .rst, .boot_done,
  .download_done, .strap_pcie_serial, .fn_sel, .pull_up_en, .pull_dn_en, .sleep_oe, .sleep_val,
  .ext_radio_grant, .pcie_reset_n, .pad_phase, .pad_in, .pad_out, .pad_oe, .pad_pull_up,
  .pad_pull_dn);
